// *** dv/gpp_board.sv ***
// Board-side model of the GPIO port: switches, pull-ups and a USB bypass oscillator.
`timescale 1ns/100ps
module gpp_board (
    input wire gpp_pkg::gpp_pins_t sw_level,
    input wire gpp_pkg::gpp_pins_t sw_drive,
    input wire gpp_pkg::gpp_pins_t gpio_out,
    input wire gpp_pkg::gpp_pins_t gpio_oe,
    input wire logic usb_clk_en,
    output gpp_pkg::gpp_pins_t gpio_in
);
    import gpp_pkg::*;
    logic osc;
    // **********************************************
    // Pin resolution
    // **********************************************
    // The oscillator is gated off outside its use, so pin 1 never carries a stale edge.
    initial osc = 1'b0;
    always #10.4 osc = usb_clk_en ? ~osc : 1'b0;
    // The port wins over a switch; an undriven pin is pulled high by its resistor.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (gpio_oe[i]) begin
                gpio_in[i] = gpio_out[i];
            end else if (i == 1 && usb_clk_en) begin
                gpio_in[i] = osc;
            end else if (sw_drive[i]) begin
                gpio_in[i] = sw_level[i];
            end else begin
                gpio_in[i] = 1'b1;
            end
        end
    end
endmodule : gpp_board

// *** dv/gpp_port_tb.sv ***
// Self-checking testbench of the GPIO port over its AXI4-Lite registers and pins.
`timescale 1ns/100ps
`include "gpp_regs.svh"
module gpp_port_tb;
    import gpp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    gpp_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    gpp_word_t s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    gpp_resp_t s_axi_bresp, s_axi_rresp;
    gpp_pins_t gpio_in, gpio_out, gpio_oe;
    gpp_pins_t sw_level = 16'hFFFF, sw_drive = 16'h0000;
    logic usb_clk_en = 1'b0;
    logic usb_byp_clk, irq;
    int num_errors = 0;
    int checks = 0;
    gpp_word_t d;
    gpp_resp_t r;
    int cyc;
    gpp_word_t it0, it1;
    always #25 aclk = ~aclk;
    gpp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .usb_byp_clk(usb_byp_clk), .irq(irq));
    gpp_board board_u (.sw_level(sw_level), .sw_drive(sw_drive), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .usb_clk_en(usb_clk_en), .gpio_in(gpio_in));
    // **********************************************
    // Shared tasks
    // **********************************************
    task results;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task guard(inout int n);
        n++;
        if (n > 200) begin
            $display("CHECK FAILED at %0t: wait of %h cycles ran out", $time, n);
            num_errors++;
            results();
        end
    endtask : guard
    task chk(input gpp_word_t got, input gpp_word_t exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input gpp_addr_t a, input gpp_word_t v, input gpp_resp_t er);
        int n;
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            guard(n);
        end
        do begin
            @(posedge aclk);
            guard(n);
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task rd(input gpp_addr_t a, output gpp_word_t v, output gpp_resp_t rr);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            guard(n);
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task rd_chk(input gpp_addr_t a, input gpp_word_t exp);
        rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(GPP_OKAY));
    endtask : rd_chk
    task half_per(input int idx, output int c);
        int n;
        logic v;
        n = 0;
        @(posedge aclk);
        v = gpio_out[idx];
        while (gpio_out[idx] === v && n < 50) begin
            @(posedge aclk);
            n++;
        end
        v = gpio_out[idx];
        c = 0;
        while (gpio_out[idx] === v && c < 50) begin
            @(posedge aclk);
            c++;
        end
    endtask : half_per
    // **********************************************
    // Main sequence
    // **********************************************
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(gpio_oe), 32'h0000_8000);
        rd_chk(`GPP_OFF_DIR, 32'h0000_0000);
        rd_chk(`GPP_OFF_CLKCFG, 32'h0000_1000);
        half_per(15, cyc);
        chk(32'(cyc), 32'h1);
        $display("test reset done");
        wr(`GPP_OFF_DIR, 32'h0000_00FF, GPP_OKAY);
        wr(`GPP_OFF_DOUT, 32'h0000_00A5, GPP_OKAY);
        repeat (6) @(posedge aclk);
        chk(32'(gpio_oe), 32'h0000_80FF);
        rd(`GPP_OFF_PIN, d, r);
        chk(d & 32'h0000_7FFF, 32'h0000_7FA5);
        $display("test direction done");
        wr(`GPP_OFF_CLKCFG, 32'h0000_1012, GPP_OKAY);
        half_per(14, cyc);
        chk(32'(cyc), 32'h3);
        chk(32'(gpio_oe), 32'h0000_C0FF);
        $display("test clock out done");
        // Pin 12 becomes an output with an edge type, so its changes must raise nothing.
        wr(`GPP_OFF_CLKCFG, 32'h0000_1000, GPP_OKAY);
        wr(`GPP_OFF_DIR, 32'h0000_1000, GPP_OKAY);
        wr(`GPP_OFF_DOUT, 32'h0000_0000, GPP_OKAY);
        sw_drive <= 16'h3FFF;
        it0 = 32'h0;
        it1 = 32'h0;
        for (int i = 0; i < 8; i++) begin
            it0 |= 32'(i < 5 ? i : 4) << (3 * i);
        end
        for (int i = 0; i < 5; i++) begin
            it1 |= 32'(GPP_IT_ANY) << (3 * i);
        end
        wr(`GPP_OFF_ITYP0, it0, GPP_OKAY);
        wr(`GPP_OFF_ITYP1, it1, GPP_OKAY);
        rd_chk(`GPP_OFF_ITYP0, it0);
        rd(`GPP_OFF_ISTAT, d, r);
        sw_level <= 16'hFFFB;
        repeat (6) @(posedge aclk);
        sw_level <= 16'hDFE5;
        wr(`GPP_OFF_DOUT, 32'h0000_1000, GPP_OKAY);
        repeat (8) @(posedge aclk);
        rd_chk(`GPP_OFF_ISTAT, 32'h0000_001F);
        rd_chk(`GPP_OFF_ISTAT, 32'h0000_0003);
        chk(32'(irq), 32'h0);
        wr(`GPP_OFF_IMASK, 32'h0000_0001, GPP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        sw_level <= 16'hDFE4;
        repeat (8) @(posedge aclk);
        chk(32'(irq), 32'h0);
        $display("test interrupts done");
        wr(`GPP_OFF_CLKCFG, 32'h0001_1000, GPP_OKAY);
        usb_clk_en <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            #3;
            chk(32'(usb_byp_clk), 32'(gpio_in[1]));
        end
        @(posedge aclk);
        usb_clk_en <= 1'b0;
        $display("test usb bypass done");
        wr(8'h40, 32'h0000_FFFF, GPP_SLVERR);
        rd(8'h40, d, r);
        chk(32'(r), 32'(GPP_SLVERR));
        wr(`GPP_OFF_PIN, 32'h0000_0000, GPP_OKAY);
        rd_chk(`GPP_OFF_DOUT, 32'h0000_1000);
        s_axi_wstrb <= 4'h2;
        wr(`GPP_OFF_DOUT, 32'h0000_34FF, GPP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd_chk(`GPP_OFF_DOUT, 32'h0000_3400);
        $display("test bus errors done");
        results();
    end
endmodule : gpp_port_tb

// *** hw/gpp_pkg.sv ***
// Types shared by the GPIO port.
package gpp_pkg;
    typedef logic [15:0] gpp_pins_t;
    typedef logic [31:0] gpp_word_t;
    typedef logic [7:0] gpp_addr_t;
    typedef enum logic [1:0] {
        GPP_OKAY = 2'h0,
        GPP_SLVERR = 2'h2
    } gpp_resp_t;
    typedef enum logic [2:0] {
        GPP_IT_HIGH = 3'h0,
        GPP_IT_LOW = 3'h1,
        GPP_IT_RISE = 3'h2,
        GPP_IT_FALL = 3'h3,
        GPP_IT_ANY = 3'h4
    } gpp_itype_t;
endpackage : gpp_pkg

// *** hw/gpp_port.sv ***
// Sixteen-pin general-purpose I/O port with interrupts and clock outputs, AXI4-Lite slave.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "gpp_regs.svh"
module gpp_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire gpp_pkg::gpp_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire gpp_pkg::gpp_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output gpp_pkg::gpp_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire gpp_pkg::gpp_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output gpp_pkg::gpp_word_t s_axi_rdata,
    output gpp_pkg::gpp_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire gpp_pkg::gpp_pins_t gpio_in,
    output gpp_pkg::gpp_pins_t gpio_out,
    output gpp_pkg::gpp_pins_t gpio_oe,
    output logic usb_byp_clk,
    output logic irq
);
    import gpp_pkg::*;

    localparam int MIN_HALF_I = (`GPP_ACLK_KHZ + 2 * `GPP_CLKOUT_MAX_KHZ - 1)
                                / (2 * `GPP_CLKOUT_MAX_KHZ);
    localparam logic [4:0] MIN_HALF = (MIN_HALF_I < 1) ? 5'h01 : 5'(MIN_HALF_I);

    function automatic logic hit(input gpp_addr_t a, input gpp_addr_t off);
        return a[7:2] == off[7:2];
    endfunction : hit

    function automatic gpp_word_t merge(input gpp_word_t old, input gpp_word_t nw,
                                        input logic [3:0] st);
        gpp_word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    gpp_addr_t awaddr_reg, awaddr_next;
    gpp_word_t wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    gpp_resp_t bresp_reg, bresp_next, rresp_reg, rresp_next;
    gpp_word_t rdata_reg, rdata_next;
    logic wr, rd_fire, wr_ok;

    gpp_pins_t dout_reg, dout_next, dir_reg, dir_next, mask_reg, mask_next;
    gpp_pins_t stat_reg, stat_next;
    logic [23:0] ityp0_reg, ityp0_next;
    logic [14:0] ityp1_reg, ityp1_next;
    logic [16:0] clkcfg_reg, clkcfg_next;
    gpp_pins_t s1_reg, s2_reg, s3_reg, stab_reg, prev_reg, stab_next;
    gpp_pins_t out_next, oe_next;
    logic ck_reg [0:1];
    logic ck_next [0:1];
    logic [4:0] cnt_reg [0:1];
    logic [4:0] cnt_next [0:1];
    logic usb_sel;
    logic [38:0] ityp_all;

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign usb_sel = clkcfg_reg[`GPP_CF_USB];
    assign ityp_all = {ityp1_reg, ityp0_reg};

    always_comb begin
        aw_hold_next = aw_hold_reg;
        awaddr_next = awaddr_reg;
        w_hold_next = w_hold_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        wr_ok = hit(awaddr_reg, `GPP_OFF_DOUT) || hit(awaddr_reg, `GPP_OFF_DIR)
             || hit(awaddr_reg, `GPP_OFF_PIN) || hit(awaddr_reg, `GPP_OFF_ITYP0)
             || hit(awaddr_reg, `GPP_OFF_ITYP1) || hit(awaddr_reg, `GPP_OFF_ISTAT)
             || hit(awaddr_reg, `GPP_OFF_IMASK) || hit(awaddr_reg, `GPP_OFF_CLKCFG);
        if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? GPP_OKAY : GPP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = GPP_OKAY;
            rdata_next = 32'h0000_0000;
            if (hit(s_axi_araddr, `GPP_OFF_DOUT)) rdata_next[15:0] = dout_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_DIR)) rdata_next[15:0] = dir_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_PIN)) rdata_next[15:0] = stab_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_ITYP0)) rdata_next[23:0] = ityp0_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_ITYP1)) rdata_next[14:0] = ityp1_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_ISTAT)) rdata_next[15:0] = stat_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_IMASK)) rdata_next[15:0] = mask_reg;
            else if (hit(s_axi_araddr, `GPP_OFF_CLKCFG)) rdata_next[16:0] = clkcfg_reg;
            else rresp_next = GPP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= GPP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= GPP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            aw_hold_reg <= aw_hold_next;
            awaddr_reg <= awaddr_next;
            w_hold_reg <= w_hold_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Registers and interrupt status
    // ************************************************************
    always_comb begin
        gpp_word_t wm;
        logic clr;
        wm = 32'h0000_0000;
        clr = rd_fire && hit(s_axi_araddr, `GPP_OFF_ISTAT);
        dout_next = dout_reg;
        dir_next = dir_reg;
        mask_next = mask_reg;
        ityp0_next = ityp0_reg;
        ityp1_next = ityp1_reg;
        clkcfg_next = clkcfg_reg;
        if (wr) begin
            if (hit(awaddr_reg, `GPP_OFF_DOUT)) begin
                wm = merge({16'h0000, dout_reg}, wdata_reg, wstrb_reg);
                dout_next = wm[15:0];
            end
            if (hit(awaddr_reg, `GPP_OFF_DIR)) begin
                wm = merge({16'h0000, dir_reg}, wdata_reg, wstrb_reg);
                dir_next = wm[15:0];
            end
            if (hit(awaddr_reg, `GPP_OFF_IMASK)) begin
                wm = merge({16'h0000, mask_reg}, wdata_reg, wstrb_reg);
                mask_next = wm[15:0];
            end
            if (hit(awaddr_reg, `GPP_OFF_ITYP0)) begin
                wm = merge({8'h00, ityp0_reg}, wdata_reg, wstrb_reg);
                ityp0_next = wm[23:0];
            end
            if (hit(awaddr_reg, `GPP_OFF_ITYP1)) begin
                wm = merge({17'h00000, ityp1_reg}, wdata_reg, wstrb_reg);
                ityp1_next = wm[14:0];
            end
            if (hit(awaddr_reg, `GPP_OFF_CLKCFG)) begin
                wm = merge({15'h0000, clkcfg_reg}, wdata_reg, wstrb_reg);
                clkcfg_next = wm[16:0];
            end
        end
        // A new edge in the cycle of the clearing read wins, so no event is lost.
        stat_next = 16'h0000;
        for (int i = 0; i < `GPP_IRQ_PINS; i++) begin
            logic live, rise, fall, kept;
            live = !dir_reg[i] && !(i == 1 && usb_sel);
            rise = stab_reg[i] && !prev_reg[i];
            fall = !stab_reg[i] && prev_reg[i];
            kept = stat_reg[i] && !clr;
            case (gpp_itype_t'(ityp_all[3*i +: 3]))
                GPP_IT_HIGH: stat_next[i] = live && stab_reg[i];
                GPP_IT_LOW: stat_next[i] = live && !stab_reg[i];
                GPP_IT_RISE: stat_next[i] = kept || (live && rise);
                GPP_IT_FALL: stat_next[i] = kept || (live && fall);
                GPP_IT_ANY: stat_next[i] = kept || (live && (rise || fall));
                default: stat_next[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_reg <= `GPP_RST_DOUT;
            dir_reg <= `GPP_RST_DIR;
            mask_reg <= 16'h0000;
            stat_reg <= 16'h0000;
            ityp0_reg <= 24'h000000;
            ityp1_reg <= 15'h0000;
            clkcfg_reg <= `GPP_RST_CLKCFG;
        end else begin
            dout_reg <= dout_next;
            dir_reg <= dir_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            ityp0_reg <= ityp0_next;
            ityp1_reg <= ityp1_next;
            clkcfg_reg <= clkcfg_next;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // ************************************************************
    // Pins: synchronisers, clock outputs, drivers
    // ************************************************************
    // A change is taken only when stages two and three agree, which rejects one-cycle glitches.
    always_comb begin
        stab_next = stab_reg;
        for (int i = 0; i < `GPP_NPINS; i++) begin
            if (s2_reg[i] == s3_reg[i]) stab_next[i] = s3_reg[i];
        end
    end

    generate
        for (genvar k = 0; k < 2; k++) begin : g_clk
            logic [4:0] half;
            logic en;
            always_comb begin
                en = clkcfg_reg[`GPP_CF_EN14 + `GPP_CF_STRIDE * k];
                half = {1'b0, clkcfg_reg[`GPP_CF_DIV14 + `GPP_CF_STRIDE * k +: 4]} + 5'h01;
                if (half < MIN_HALF) half = MIN_HALF;
                cnt_next[k] = cnt_reg[k] + 5'h01;
                ck_next[k] = ck_reg[k];
                if (!en) begin
                    cnt_next[k] = 5'h00;
                    ck_next[k] = 1'b0;
                end else if (cnt_reg[k] >= half - 5'h01) begin
                    cnt_next[k] = 5'h00;
                    ck_next[k] = !ck_reg[k];
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_reg[k] <= 5'h00;
                    ck_reg[k] <= 1'b0;
                end else begin
                    cnt_reg[k] <= cnt_next[k];
                    ck_reg[k] <= ck_next[k];
                end
            end
        end
    endgenerate

    always_comb begin
        out_next = dout_reg;
        oe_next = dir_reg;
        if (usb_sel) oe_next[1] = 1'b0;
        if (g_clk[0].en) begin
            oe_next[14] = 1'b1;
            out_next[14] = ck_reg[0];
        end
        if (g_clk[1].en) begin
            oe_next[15] = 1'b1;
            out_next[15] = ck_reg[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 16'h0000;
            s2_reg <= 16'h0000;
            s3_reg <= 16'h0000;
            stab_reg <= 16'h0000;
            prev_reg <= 16'h0000;
            gpio_out <= `GPP_RST_DOUT;
            gpio_oe <= `GPP_RST_OE;
        end else begin
            s1_reg <= gpio_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stab_reg <= stab_next;
            prev_reg <= stab_reg;
            gpio_out <= out_next;
            gpio_oe <= oe_next;
        end
    end

    // The bypass clock is far faster than aclk, so it is gated straight through, never sampled.
    assign usb_byp_clk = usb_sel & gpio_in[1];

    // ************************************************************
    // Assertions
    // ************************************************************
    a_dir_to_oe: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> gpio_oe[13:2] == $past(dir_reg[13:2]) && gpio_oe[0] == $past(dir_reg[0]))
        else $error("pin drive does not follow direction");
    a_no_high_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_reg[15:13] == 3'h0 and (dir_reg[0] |=> !$rose(stat_reg[0]))
        and ((dir_reg[1] || usb_sel) |=> !$rose(stat_reg[1])))
        else $error("interrupt on pin without capability");
    a_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        (ityp0_reg[8:6] == GPP_IT_RISE && !dir_reg[2] && stab_reg[2] && !prev_reg[2])
        |=> stat_reg[2] ##0 (!mask_reg[2] || irq))
        else $error("rising edge not latched");
    a_clk_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        g_clk[0].en |=> gpio_oe[14] && gpio_out[14] == $past(ck_reg[0]))
        else $error("clock output not on pin 14");
    a_clk_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        (g_clk[1].en && $past(g_clk[1].en) && ck_reg[1] != $past(ck_reg[1]))
        |-> $past(cnt_reg[1]) + 5'h01 >= $past(g_clk[1].half))
        else $error("clock output too fast");
    a_reset_inputs: assert property (@(posedge aclk)
        !aresetn |=> gpio_oe == `GPP_RST_OE && dir_reg == 16'h0000)
        else $error("pins not inputs after reset");
    a_reset_clk15: assert property (@(posedge aclk)
        !aresetn ##1 aresetn [*3] |=> gpio_oe[15] && g_clk[1].en)
        else $error("pin 15 not driving clock after reset");
    a_usb_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
        usb_sel |=> !gpio_oe[1] && usb_byp_clk == gpio_in[1])
        else $error("bypass clock path broken");
    a_edge_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_reg[4] && ityp0_reg[14:12] == GPP_IT_ANY
         && !(rd_fire && hit(s_axi_araddr, `GPP_OFF_ISTAT))
         && $stable(ityp0_reg)) |=> stat_reg[4])
        else $error("edge flag lost without clear");
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr);
    c_read_clr: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && hit(s_axi_araddr, `GPP_OFF_ISTAT) && stat_reg != 16'h0000);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : gpp_port

// *** hw/gpp_regs.svh ***
// Register offsets, field positions, reset values and timing constants of the GPIO port.
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH
`define GPP_OFF_DOUT 8'h00
`define GPP_OFF_DIR 8'h04
`define GPP_OFF_PIN 8'h08
`define GPP_OFF_ITYP0 8'h0C
`define GPP_OFF_ITYP1 8'h10
`define GPP_OFF_ISTAT 8'h14
`define GPP_OFF_IMASK 8'h18
`define GPP_OFF_CLKCFG 8'h1C
`define GPP_NPINS 16
`define GPP_IRQ_PINS 13
`define GPP_CF_DIV14 0
`define GPP_CF_EN14 4
`define GPP_CF_STRIDE 8
`define GPP_CF_EN15 12
`define GPP_CF_USB 16
`define GPP_RST_DOUT 16'h0000
`define GPP_RST_DIR 16'h0000
`define GPP_RST_OE 16'h8000
`define GPP_RST_CLKCFG 17'h01000
`define GPP_ACLK_KHZ 20000
`define GPP_CLKOUT_MAX_KHZ 33330
`endif
